// file: rtl/fuzzy_online_engine.sv
// on-line phase of the fuzzy inference co-processor
`timescale 1ns/1ps

module fuzzy_online_engine
  import fuzzy_pkg::*;
#(
  parameter logic [15:0] CONV_W4 = 16'h1FE0,
  parameter logic [15:0] CONV_W5 = 16'h3FC0,
  parameter logic [15:0] CONV_W6 = 16'h7D00,
  parameter logic [15:0] CONV_W7 = 16'hFFF0
) (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  // register bus
  input  wire logic [11:0] avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // input pins
  input  wire logic [7:0]  input_bus,
  input  wire logic [2:0]  input_select_lines,
  input  wire logic        rd_strobe,
  input  wire logic        final_input_flag,
  input  wire logic        wait_req,
  input  wire logic        restart_n,
  input  wire logic        offline_select,
  input  wire logic        auto_boot,
  // output pins
  output logic      [7:0]  result_bus,
  output logic      [2:0]  next_input_index,
  output logic             conversion_start_pulse,
  output logic      [1:0]  output_index_lines,
  output logic             result_strobe,
  output logic             ready,
  output logic             busy
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] be_merge(input logic [31:0] old_w,
                                           input logic [31:0] new_w,
                                           input logic [3:0]  be);
    logic [31:0] r;
    r = old_w;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[b*8 +: 8] = new_w[b*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [15:0] conv_width(input logic [2:0] code);
    case (code)
      3'h0:    return CONV_W0;
      3'h1:    return CONV_W1;
      3'h2:    return CONV_W2;
      3'h3:    return CONV_W3;
      3'h4:    return CONV_W4;
      3'h5:    return CONV_W5;
      3'h6:    return CONV_W6;
      default: return CONV_W7;
    endcase
  endfunction

  eng_t        s_q;
  eng_t        s_d;
  pin_t        pins;
  logic        rd_act;
  logic        fin_act;
  logic        stall_act;
  logic        off_edge;
  logic        start_elab;
  logic        fin_now;
  logic [7:0]  in_mask;
  logic [31:0] rd_word;
  logic [31:0] wr_word;
  logic [31:0] ctrl_word;
  logic [31:0] ant_w;
  logic [15:0] cons_w;
  logic [7:0]  x_in;
  logic [31:0] mf_w;
  logic [15:0] up_v;
  logic [15:0] dn_v;
  logic [15:0] al_v;
  logic [15:0] prod;
  logic [20:0] quo;
  logic [3:0][7:0] lit;
  logic [3:0][7:0] chain;

  assign pins = '{data: input_bus, sel: input_select_lines, rd: rd_strobe,
                  fin: final_input_flag, stall: wait_req, restart_n: restart_n,
                  offline: offline_select, auto_boot: auto_boot};

  // handshake levels compared against their programmed polarity
  assign rd_act    = (s_q.sync2.rd == s_q.pol[POL_RD]);
  assign fin_act   = (s_q.sync2.fin == s_q.pol[POL_FINAL]);
  assign stall_act = (s_q.sync2.stall == s_q.pol[POL_WAIT]);
  assign off_edge  = (s_q.sync2.offline != s_q.off_prev);

  assign ctrl_word = {17'h0, s_q.pw, 3'h0, s_q.master, 2'h0, s_q.nout, 1'b0, s_q.nin};
  assign ant_w     = s_q.ant[s_q.idx[4:0]];
  assign cons_w    = s_q.cons[s_q.idx[4:0]];

  // ----------------------------------------------------------------
  // activation level of one membership function (trapezoid by slopes)
  // ----------------------------------------------------------------
  assign x_in = s_q.inval[s_q.idx[5:3]];
  assign mf_w = s_q.mf[s_q.idx];
  assign up_v = 16'(x_in - mf_w[7:0]) * 16'(mf_w[MF_SU_LSB +: 8]);
  assign dn_v = 16'(mf_w[MF_B_LSB +: 8] - x_in) * 16'(mf_w[MF_SD_LSB +: 8]);
  assign al_v = (up_v < dn_v) ? up_v : dn_v;

  // ----------------------------------------------------------------
  // rule weight: up to four literals, each direct or negated
  // ----------------------------------------------------------------
  for (genvar k = 0; k < 4; k++) begin : g_lit
    assign lit[k] = ant_w[k*ANT_W + ANT_NEG] ? ~s_q.alpha[ant_w[k*ANT_W +: 6]]
                                             : s_q.alpha[ant_w[k*ANT_W +: 6]];
    if (k == 0) begin : g_first
      assign chain[k] = lit[k];
    end else begin : g_next
      // OR takes the larger level, AND the smaller
      assign chain[k] = (k > cons_w[CONS_NANT_LSB +: 2]) ? chain[k-1] :
                        (ant_w[ANT_OP] == (lit[k] > chain[k-1])) ? lit[k] :
                        chain[k-1];
    end
  end

  assign prod = 16'(s_q.theta) * 16'(cons_w[7:0]);
  assign quo  = (s_q.den[s_q.ocnt] == 13'h0) ? 21'h0 :
                s_q.num[s_q.ocnt] / 21'(s_q.den[s_q.ocnt]);

  // inputs 0..nin must all be refreshed before an unforced start
  for (genvar i = 0; i < 8; i++) begin : g_mask
    assign in_mask[i] = (i <= s_q.nin);
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    s_d        = s_q;
    start_elab = 1'b0;
    fin_now    = 1'b0;
    wr_word    = 32'h0;
    s_d.sync1  = pins;
    s_d.sync2  = s_q.sync1;
    s_d.off_prev = s_q.sync2.offline;

    // register bus: one-cycle answer, then waitrequest back high
    rd_word = 32'h0;
    case (avs_address[11:8])
      4'h0: begin
        if (avs_address == CTRL_OFS) begin
          rd_word = ctrl_word;
        end else if (avs_address == POL_OFS) begin
          rd_word = {24'h0, s_q.pol};
        end else if (avs_address == NRULE_OFS) begin
          rd_word = {26'h0, s_q.nrule};
        end else if (avs_address == STATUS_OFS) begin
          rd_word = {16'h0, s_q.got, 3'h0, s_q.busy_l, s_q.st};
        end else if (avs_address[11:5] == INVAL_OFS[11:5]) begin
          rd_word = {24'h0, s_q.inval[avs_address[4:2]]};
        end
      end
      PAGE_MF:   rd_word = s_q.mf[avs_address[7:2]];
      PAGE_ANT:  rd_word = avs_address[7] ? 32'h0 : s_q.ant[avs_address[6:2]];
      PAGE_CONS: rd_word = avs_address[7] ? 32'h0 : {16'h0, s_q.cons[avs_address[6:2]]};
      default:   rd_word = 32'h0;
    endcase
    s_d.ack     = 1'b0;
    s_d.waitreq = 1'b1;
    if ((avs_read || avs_write) && !s_q.ack) begin
      s_d.ack     = 1'b1;
      s_d.waitreq = 1'b0;
      s_d.rdata   = avs_read ? rd_word : 32'h0;
      if (avs_write) begin
        wr_word = be_merge(rd_word, avs_writedata, avs_byteenable);
        if (avs_address == CTRL_OFS) begin
          s_d.nin    = wr_word[CTRL_NIN_LSB +: 3];
          s_d.nout   = wr_word[CTRL_NOUT_LSB +: 2];
          s_d.master = wr_word[CTRL_MASTER];
          s_d.pw     = wr_word[CTRL_PW_LSB +: 3];
        end else if (avs_address == POL_OFS) begin
          s_d.pol = wr_word[7:0];
        end else if (avs_address == NRULE_OFS) begin
          s_d.nrule = wr_word[5:0];
        end else if (avs_address[11:8] == PAGE_MF) begin
          s_d.mf[avs_address[7:2]] = wr_word;
        end else if (avs_address[11:8] == PAGE_ANT && !avs_address[7]) begin
          s_d.ant[avs_address[6:2]] = wr_word;
        end else if (avs_address[11:8] == PAGE_CONS && !avs_address[7]) begin
          s_d.cons[avs_address[6:2]] = wr_word[15:0];
        end
      end
    end

    // on-line engine
    if (s_q.hold != 2'h0) begin
      s_d.hold = 2'(s_q.hold - 2'h1);
    end
    if (!s_q.sync2.restart_n || off_edge) begin
      s_d.hold   = RESTART_HOLD;
      s_d.st     = S_IDLE;
      s_d.rdy_l  = 1'b0;
      s_d.busy_l = 1'b0;
      s_d.stb_l  = 1'b0;
      s_d.in_ptr = 3'h0;
      s_d.fin_seen = 1'b0;
    end else if (s_q.hold == 2'h0 && !s_q.sync2.offline) begin
      case (s_q.st)
        S_IDLE: begin
          if (rd_act) begin
            // select lines were stable before the strobe, so sampled with it
            s_d.idx[2:0] = s_q.master ? s_q.in_ptr : s_q.sync2.sel;
            s_d.inval[s_d.idx[2:0]] = s_q.sync2.data;
            s_d.got[s_d.idx[2:0]]   = 1'b1;
            s_d.fin_seen = fin_act && !s_q.master;
            s_d.cnt = 6'h0;
            s_d.st  = S_ACQ;
          end else if (fin_act && !s_q.master) begin
            start_elab = 1'b1;
          end
        end
        S_ACQ: begin
          s_d.cnt = 6'(s_q.cnt + 6'h1);
          if (s_q.cnt == 6'(ACQ_CYCLES - 4'h1)) begin
            s_d.rdy_l = 1'b1;
            s_d.st    = S_HOLD;
          end
        end
        S_HOLD: begin
          if (!rd_act) begin
            s_d.rdy_l = 1'b0;
            fin_now   = s_q.fin_seen || (fin_act && !s_q.master);
            if (s_q.master) begin
              s_d.in_ptr = 3'(s_q.in_ptr + 3'h1);
              start_elab = (s_q.in_ptr == s_q.nin);
            end else begin
              start_elab = fin_now || ((s_q.got & in_mask) == in_mask);
            end
            s_d.st = S_IDLE;
          end
        end
        S_ALPHA: begin
          if (x_in < mf_w[7:0] || x_in > mf_w[MF_B_LSB +: 8]) begin
            s_d.alpha[s_q.idx] = 8'h0;
          end else begin
            s_d.alpha[s_q.idx] = (al_v > 16'(ALPHA_MAX)) ? ALPHA_MAX : al_v[7:0];
          end
          s_d.idx = 6'(s_q.idx + 6'h1);
          if (s_q.idx == 6'h3F) begin
            s_d.idx = 6'h0;
            s_d.cnt = 6'h0;
            s_d.num = '0;
            s_d.den = '0;
            s_d.st  = (s_q.nrule == 6'h0) ? S_DIV : S_RULE;
          end
        end
        S_RULE: begin
          s_d.cnt = 6'(s_q.cnt + 6'h1);
          if (s_q.cnt == 6'h0) begin
            s_d.theta = chain[3];
          end
          if (s_q.cnt == 6'(RULE_CYCLES - 6'h1)) begin
            s_d.num[cons_w[CONS_OUT_LSB +: 2]] =
              21'(s_q.num[cons_w[CONS_OUT_LSB +: 2]] + 21'(prod));
            s_d.den[cons_w[CONS_OUT_LSB +: 2]] =
              13'(s_q.den[cons_w[CONS_OUT_LSB +: 2]] + 13'(s_q.theta));
            s_d.cnt = 6'h0;
            s_d.idx = 6'(s_q.idx + 6'h1);
            if (s_q.idx == 6'(s_q.nrule - 6'h1)) begin
              s_d.st   = S_DIV;
            end
          end
        end
        S_DIV: begin
          s_d.result = (quo > 21'(ALPHA_MAX)) ? ALPHA_MAX : quo[7:0];
          s_d.st     = S_EMIT;
        end
        S_EMIT: begin
          if (!stall_act) begin
            s_d.res_o  = s_q.result;
            s_d.oidx_o = s_q.ocnt;
            s_d.stb_l  = 1'b1;
            s_d.cnt    = 6'h0;
            s_d.st     = S_STROBE;
          end
        end
        S_STROBE: begin
          s_d.cnt = 6'(s_q.cnt + 6'h1);
          if (s_q.cnt == 6'(STROBE_CYCLES - 2'h1)) begin
            s_d.stb_l = 1'b0;
            if (s_q.ocnt == s_q.nout) begin
              s_d.busy_l = 1'b0;
              s_d.st     = S_IDLE;
            end else begin
              s_d.ocnt = 2'(s_q.ocnt + 2'h1);
              s_d.st   = S_DIV;
            end
          end
        end
        default: s_d.st = S_IDLE;
      endcase
      if (start_elab) begin
        // acquisition only restarts from idle, i.e. after busy dropped
        s_d.busy_l   = 1'b1;
        s_d.got      = 8'h0;
        s_d.fin_seen = 1'b0;
        s_d.in_ptr   = 3'h0;
        s_d.idx      = 6'h0;
        s_d.ocnt     = 2'h0;
        s_d.st       = S_ALPHA;
      end
    end

    // pulse after busy or offline falls, none while auto_boot is high; after offline it first sits out the forced-low hold
    if (s_q.conv_cnt != 16'h0) begin
      s_d.conv_cnt = 16'(s_q.conv_cnt - 16'h1);
    end else begin
      s_d.conv_l = 1'b0;
    end
    if ((s_q.busy_l && !s_d.busy_l && s_d.hold == 2'h0) ||
        (s_q.off_prev && !s_q.sync2.offline)) begin
      s_d.conv_l   = 1'b1;
      s_d.conv_cnt = 16'(conv_width(s_q.pw) + (off_edge ? 16'(RESTART_HOLD) : 16'h0) - 16'h1);
    end
    if (s_q.sync2.auto_boot) begin
      s_d.conv_l   = 1'b0;
      s_d.conv_cnt = 16'h0;
    end

    // pin levels
    s_d.rdy_o  = s_d.rdy_l  ? s_d.pol[POL_READY]  : ~s_d.pol[POL_READY];
    s_d.busy_o = s_d.busy_l ? s_d.pol[POL_BUSY]   : ~s_d.pol[POL_BUSY];
    s_d.stb_o  = s_d.stb_l  ? s_d.pol[POL_STROBE] : ~s_d.pol[POL_STROBE];
    s_d.conv_o = s_d.conv_l ? s_d.pol[POL_CONV]   : ~s_d.pol[POL_CONV];
    s_d.nxt_o  = s_d.master ? s_d.in_ptr : 3'h0;
    if (s_d.hold != 2'h0 || !s_q.sync2.restart_n) begin
      s_d.res_o  = 8'h0;
      s_d.oidx_o = 2'h0;
      s_d.nxt_o  = 3'h0;
      s_d.conv_o = 1'b0;
      s_d.conv_l = s_d.conv_l && s_q.sync2.restart_n && !s_q.sync2.offline;
      s_d.conv_cnt = s_d.conv_l ? s_d.conv_cnt : 16'h0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      s_q         <= '0;
      s_q.pol     <= POL_RST;
      s_q.waitreq <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign avs_readdata           = s_q.rdata;
  assign avs_waitrequest        = s_q.waitreq;
  assign result_bus             = s_q.res_o;
  assign next_input_index       = s_q.nxt_o;
  assign conversion_start_pulse = s_q.conv_o;
  assign output_index_lines     = s_q.oidx_o;
  assign result_strobe          = s_q.stb_o;
  assign ready                  = s_q.rdy_o;
  assign busy                   = s_q.busy_o;

endmodule // fuzzy_online_engine

// file: rtl/fuzzy_pkg.sv
// constants, field layouts and state types of the fuzzy on-line engine
package fuzzy_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [11:0] CTRL_OFS   = 12'h000;
  localparam logic [11:0] POL_OFS    = 12'h004;
  localparam logic [11:0] NRULE_OFS  = 12'h008;
  localparam logic [11:0] STATUS_OFS = 12'h00C;
  localparam logic [11:0] INVAL_OFS  = 12'h040;
  localparam logic [3:0]  PAGE_MF    = 4'h1;
  localparam logic [3:0]  PAGE_ANT   = 4'h2;
  localparam logic [3:0]  PAGE_CONS  = 4'h3;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CTRL_NIN_LSB   = 0;
  localparam int CTRL_NOUT_LSB  = 4;
  localparam int CTRL_MASTER    = 8;
  localparam int CTRL_PW_LSB    = 12;
  localparam int POL_READY      = 0;
  localparam int POL_RD         = 1;
  localparam int POL_WAIT       = 2;
  localparam int POL_STROBE     = 3;
  localparam int POL_BUSY       = 4;
  localparam int POL_FINAL      = 5;
  localparam int POL_CONV       = 7;
  localparam int STAT_BUSY      = 4;
  localparam int STAT_GOT_LSB   = 8;
  localparam int MF_B_LSB       = 8;
  localparam int MF_SU_LSB      = 16;
  localparam int MF_SD_LSB      = 24;
  localparam int ANT_W          = 7;
  localparam int ANT_NEG        = 6;
  localparam int ANT_OP         = 28;
  localparam int CONS_OUT_LSB   = 8;
  localparam int CONS_NANT_LSB  = 10;

  // ----------------------------------------------------------------
  // reset values and timing counts (master clock cycles)
  // ----------------------------------------------------------------
  localparam logic [7:0]  POL_RST       = 8'hFF;
  localparam logic [3:0]  ACQ_CYCLES    = 4'h8;
  localparam logic [5:0]  RULE_CYCLES   = 6'h20;
  localparam logic [1:0]  RESTART_HOLD  = 2'h3;
  localparam logic [1:0]  STROBE_CYCLES = 2'h2;
  localparam logic [15:0] CONV_W0       = 16'h0080;
  localparam logic [15:0] CONV_W1       = 16'h0100;
  localparam logic [15:0] CONV_W2       = 16'h07F8;
  localparam logic [15:0] CONV_W3       = 16'h0FF0;
  localparam logic [7:0]  ALPHA_MAX     = 8'hFF;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    S_IDLE   = 4'h0,
    S_ACQ    = 4'h1,
    S_HOLD   = 4'h2,
    S_ALPHA  = 4'h3,
    S_RULE   = 4'h4,
    S_DIV    = 4'h5,
    S_EMIT   = 4'h6,
    S_STROBE = 4'h7
  } fsm_t;

  typedef struct packed {
    logic [7:0] data;
    logic [2:0] sel;
    logic       rd;
    logic       fin;
    logic       stall;
    logic       restart_n;
    logic       offline;
    logic       auto_boot;
  } pin_t;

  typedef struct packed {
    pin_t              sync1;
    pin_t              sync2;
    logic              off_prev;
    fsm_t              st;
    logic [2:0]        nin;
    logic [1:0]        nout;
    logic              master;
    logic [2:0]        pw;
    logic [7:0]        pol;
    logic [5:0]        nrule;
    logic [7:0][7:0]   inval;
    logic [7:0]        got;
    logic              fin_seen;
    logic [2:0]        in_ptr;
    logic [63:0][31:0] mf;
    logic [31:0][31:0] ant;
    logic [31:0][15:0] cons;
    logic [63:0][7:0]  alpha;
    logic [5:0]        cnt;
    logic [5:0]        idx;
    logic [1:0]        ocnt;
    logic [3:0][20:0]  num;
    logic [3:0][12:0]  den;
    logic [7:0]        theta;
    logic [7:0]        result;
    logic [1:0]        hold;
    logic [15:0]       conv_cnt;
    logic              rdy_l;
    logic              busy_l;
    logic              stb_l;
    logic              conv_l;
    logic [7:0]        res_o;
    logic [2:0]        nxt_o;
    logic [1:0]        oidx_o;
    logic              rdy_o;
    logic              busy_o;
    logic              stb_o;
    logic              conv_o;
    logic              ack;
    logic              waitreq;
    logic [31:0]       rdata;
  } eng_t;

endpackage

// file: sim/engine_props.sv
// pin-level checks of the fuzzy on-line engine
`timescale 1ns/1ps

module engine_props (
  // clock, reset, bus
  input wire logic       core_clk,
  input wire logic       sys_rst,
  input wire logic       avs_read,
  input wire logic       avs_write,
  input wire logic       avs_waitrequest,
  // pins
  input wire logic       rd_strobe,
  input wire logic       restart_n,
  input wire logic       ready,
  input wire logic       busy,
  input wire logic       result_strobe,
  input wire logic [7:0] result_bus,
  input wire logic [1:0] output_index_lines,
  input wire logic       conversion_start_pulse
);
  // ------
  // checks
  // ------
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  sequence rdy_tail;
    ready [*2] ##1 !ready;
  endsequence
  sequence stb_two;
    result_strobe ##1 !result_strobe;
  endsequence
  bus_answer_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus answer late");
  ack_one_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("bus answer too long");
  ready_late_a: assert property ($rose(ready) |-> $past(rd_strobe, 11) && !$past(rd_strobe, 12))
    else $error("ready latency wrong");
  ready_drop_a: assert property ($fell(rd_strobe) && ready |=> rdy_tail)
    else $error("ready release wrong");
  busy_quiet_a: assert property (busy |-> !ready)
    else $error("ready while busy");
  strobe_len_a: assert property ($rose(result_strobe) |=> stb_two)
    else $error("strobe length wrong");
  strobe_hold_a: assert property ($rose(result_strobe) |=> $stable(result_bus) [*2])
    else $error("result moved in strobe");
  restart_clr_a: assert property (!restart_n [*5] |-> result_bus == 8'h00 &&
    output_index_lines == 2'h0 && !conversion_start_pulse) else $error("restart left outputs");
endmodule // engine_props

bind fuzzy_online_engine engine_props u_props (.core_clk, .sys_rst, .avs_read, .avs_write,
  .avs_waitrequest, .rd_strobe, .restart_n, .ready, .busy, .result_strobe, .result_bus,
  .output_index_lines, .conversion_start_pulse);

// file: sim/host_link.sv
// host model: feeds crisp inputs and collects results
`timescale 1ns/1ps

module host_link (
  // from the engine
  input wire logic       core_clk,
  input wire logic       ready,
  input wire logic       busy,
  input wire logic       result_strobe,
  input wire logic [7:0] result_bus,
  // to the engine
  output logic     [7:0] input_bus,
  output logic     [2:0] input_select_lines,
  output logic           rd_strobe,
  output logic           final_input_flag,
  output logic           wait_req
);
  logic       stall = 1'b0;
  logic       seen = 1'b0;
  logic [7:0] got = 8'h00;
  int         n_res = 0;
  assign wait_req = stall;
  initial begin
    input_bus = 8'h00;
    input_select_lines = 3'h0;
    rd_strobe = 1'b0;
    final_input_flag = 1'b0;
  end
  always @(posedge core_clk) begin
    seen <= result_strobe;
    if (result_strobe && !seen) begin
      got <= result_bus;
      n_res <= n_res + 1;
    end
  end
  // waits are bounded; a lost answer is left to the bench watchdog
  task automatic send(input logic [7:0] d, input logic [2:0] s, input logic f);
    int n;
    n = 0;
    while (busy !== 1'b0 && n++ < 3000) @(posedge core_clk);
    @(posedge core_clk);
    input_bus <= d;
    input_select_lines <= s;
    @(posedge core_clk);
    // a final flag seen alone while idle starts elaboration, so it rises with the strobe
    final_input_flag <= f;
    rd_strobe <= 1'b1;
    while (ready !== 1'b1 && n++ < 6000) @(posedge core_clk);
    rd_strobe <= 1'b0;
    final_input_flag <= 1'b0;
    input_bus <= ~d;
    while (ready !== 1'b0 && n++ < 9000) @(posedge core_clk);
  endtask
endmodule // host_link

// file: sim/tb_fuzzy_online_engine.sv
// self-checking bench of the fuzzy on-line engine
`timescale 1ns/1ps
`define CHK(n, e, a) begin checked++; if ((a) !== (e)) begin error_cnt++; \
  $display("ERROR %s exp %h got %h", n, e, a); end end

module tb_fuzzy_online_engine
  import fuzzy_pkg::*;
;
  logic        core_clk, sys_rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0;
  logic [11:0] avs_address = 12'h000;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, rdat;
  logic [7:0]  input_bus, result_bus;
  logic [2:0]  input_select_lines, next_input_index;
  logic [1:0]  output_index_lines;
  logic        avs_waitrequest, rd_strobe, final_input_flag, wait_req, ready, busy;
  logic        result_strobe, conversion_start_pulse;
  logic        restart_n = 1'b1, offline_select = 1'b0, auto_boot = 1'b0;
  int          error_cnt = 0, checked = 0, nres = 0, n;
  logic [11:0] ca [7] = '{CTRL_OFS, NRULE_OFS, 12'h100, 12'h200, 12'h204, 12'h300, 12'h304};
  logic [31:0] cd [7] = '{32'h1, 32'h2, 32'hFF01FF00, 32'h0, 32'h40, 32'h0, 32'hFF};
  logic [15:0] wid [9] = '{CONV_W0, CONV_W1, CONV_W2, CONV_W3, 16'h10, 16'h11, 16'h12,
                           16'h13, 16'h0};
  fuzzy_online_engine #(.CONV_W4(16'h10), .CONV_W5(16'h11), .CONV_W6(16'h12),
    .CONV_W7(16'h13)) dut (.core_clk, .sys_rst, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable(4'hF), .avs_readdata, .avs_waitrequest, .input_bus,
    .input_select_lines, .rd_strobe, .final_input_flag, .wait_req, .restart_n,
    .offline_select, .auto_boot, .result_bus, .next_input_index, .conversion_start_pulse,
    .output_index_lines, .result_strobe, .ready, .busy);
  host_link u_host (.core_clk, .ready, .busy, .result_strobe, .result_bus, .input_bus,
    .input_select_lines, .rd_strobe, .final_input_flag, .wait_req);
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  // -----
  // tasks
  // -----
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge core_clk);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
    rdat = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic get(input logic [7:0] e, input logic [1:0] i);
    while (u_host.n_res == nres) @(posedge core_clk);
    nres = u_host.n_res;
    `CHK("result", e, u_host.got)
    `CHK("index", i, output_index_lines)
  endtask
  task automatic stop_test;
    $display("checked %0d error_cnt %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge core_clk);
    error_cnt++;
    stop_test();
  end
  // ------
  // tests
  // ------
  initial begin
    repeat (20) @(posedge core_clk);
    sys_rst <= 1'b0;
    repeat (3) @(posedge core_clk);
    bus(0, POL_OFS, 32'h0);
    `CHK("polarity", 32'hFF, rdat)
    bus(1, POL_OFS, 32'hEF);
    `CHK("busy level", 1'b1, busy)
    bus(1, POL_OFS, 32'hFF);
    bus(0, 12'h0F0, 32'h0);
    `CHK("unmapped", 32'h0, rdat)
    for (int i = 0; i < 7; i++) bus(1, ca[i], cd[i]);
    u_host.send(8'h40, 3'h0, 1'b0);
    u_host.send(8'h11, 3'h1, 1'b0);
    get(8'hBF, 2'h0);
    u_host.send(8'h22, 3'h1, 1'b1);
    get(8'hBF, 2'h0);
    bus(0, INVAL_OFS + 12'h4, 32'h0);
    `CHK("stored", 32'h22, rdat)
    $display("slave test ends");
    u_host.stall <= 1'b1;
    u_host.send(8'h80, 3'h0, 1'b1);
    repeat (400) @(posedge core_clk);
    `CHK("held", nres, u_host.n_res)
    u_host.stall <= 1'b0;
    get(8'h7F, 2'h0);
    // two outputs; output 1 owns no rule, so its weight sum is zero
    bus(1, CTRL_OFS, 32'h111);
    `CHK("next", 3'h0, next_input_index)
    u_host.send(8'h10, 3'h7, 1'b0);
    `CHK("next", 3'h1, next_input_index)
    u_host.send(8'h20, 3'h7, 1'b0);
    get(8'hEF, 2'h0);
    get(8'h00, 2'h1);
    @(posedge core_clk);
    `CHK("busy pulse", 1'b1, conversion_start_pulse)
    restart_n <= 1'b0;
    repeat (6) @(posedge core_clk);
    `CHK("restart", 8'h00, result_bus)
    restart_n <= 1'b1;
    $display("master test ends");
    for (int c = 0; c < 9; c++) begin
      auto_boot <= (c == 8);
      bus(1, CTRL_OFS, {17'h0, c[2:0], 12'h001});
      offline_select <= 1'b1;
      repeat (4) @(posedge core_clk);
      offline_select <= 1'b0;
      n = 0;
      while (!conversion_start_pulse && n++ < 50) @(posedge core_clk);
      n = 0;
      while (conversion_start_pulse && n < 70000) begin
        @(posedge core_clk);
        n++;
      end
      `CHK("pulse", wid[c], n[15:0])
    end
    $display("pulse test ends");
    stop_test();
  end
endmodule // tb_fuzzy_online_engine
